/* cts_pkg.sv */
// Constants for camera trigger and strobe port control
package cts_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] TDLY_OFS   = 8'h04;
  localparam logic [7:0] TWID_OFS   = 8'h08;
  localparam logic [7:0] SDLY_OFS   = 8'h0c;
  localparam logic [7:0] SWID_OFS   = 8'h10;
  localparam logic [7:0] STAT_OFS   = 8'h14;
  // Control field positions
  localparam int TRIG_INV_BIT = 0;
  localparam int OUT_SEL_BIT  = 1;
  localparam int OUT_INV_BIT  = 2;
  // Status field positions
  localparam int MON_TRIG_BIT = 0;
  localparam int MON_OUT_BIT  = 1;
  localparam int READY_BIT    = 2;
  // Field widths and upper limits in microseconds
  localparam int TDLY_W   = 20;
  localparam int TWID_W   = 15;
  localparam int STRB_W   = 12;
  localparam int TDLY_MAX = 1000000;
  localparam int TWID_MAX = 20000;
  localparam int STRB_MAX = 4095;
  // Reset values
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // Timing: one microsecond tick from the 10 ns clock
  localparam int CLK_NS   = 10;
  localparam int TICK_NS  = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // Bus responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_QUAL,
    ST_TDLY,
    ST_SDLY,
    ST_SON
  } cts_state_e;
endpackage

/* cts_trigger_strobe.sv */
// Trigger conditioning, shutter release and output port control
// Notes on behaviour
// R1 - Trigger invert selects off or on as active
// R2 - Wait programmed delay before shutter release
// R3 - Trigger needs programmed minimum active width
// R4 - Ready selection: output active while idle
// R5 - Strobe selection: pulse per exposure
// R6 - Output invert turns photocoupler off when active
// R7 - Strobe delay and width apply only in strobe
// R8 - Monitor bit shows trigger input state
// R9 - Monitor bit shows output port state
// R10 - One microsecond tick times all delays
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module cts_trigger_strobe (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        trigger_input_port,
  output logic             shutter_release,
  output logic             out_port
);

  logic [2:0]              ctrl_ff;
  logic [cts_pkg::TDLY_W-1:0] tdly_ff;
  logic [cts_pkg::TWID_W-1:0] twid_ff;
  logic [cts_pkg::STRB_W-1:0] sdly_ff;
  logic [cts_pkg::STRB_W-1:0] swid_ff;
  logic [7:0]              awaddr_ff;
  logic [31:0]             wdata_ff;
  logic [3:0]              wstrb_ff;
  logic                    do_wr;
  logic [31:0]             wmask;
  logic [6:0]              div_ff;
  logic                    tick_ff;
  logic                    div_clr;
  logic [6:0]              gap_ff;
  logic                    tick_ok_ff;
  logic [2:0]              sync_ff;
  logic                    trig_on_ff;
  logic                    act_prev_ff;
  logic                    trig_act;
  logic [19:0]             cnt_ff;
  logic [19:0]             limit;
  logic                    limit_hit;
  cts_pkg::cts_state_e     st_ff;
  cts_pkg::cts_state_e     nxt_st;
  logic                    nxt_out;

  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                  {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

  // Write address and data capture, response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= cts_pkg::RESP_OK;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_ff     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_ff <= cts_pkg::SWID_OFS &&
                         awaddr_ff[1:0] == 2'h0) ?
                        cts_pkg::RESP_OK : cts_pkg::RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Setting registers with byte lane merge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= cts_pkg::REG_RST[2:0];
      tdly_ff <= cts_pkg::REG_RST[cts_pkg::TDLY_W-1:0];
      twid_ff <= cts_pkg::REG_RST[cts_pkg::TWID_W-1:0];
      sdly_ff <= cts_pkg::REG_RST[cts_pkg::STRB_W-1:0];
      swid_ff <= cts_pkg::REG_RST[cts_pkg::STRB_W-1:0];
    end else if (do_wr) begin
      case (awaddr_ff)
        cts_pkg::CTRL_OFS:
          ctrl_ff <= (ctrl_ff & ~wmask[2:0]) | (wdata_ff[2:0] & wmask[2:0]);
        cts_pkg::TDLY_OFS:
          tdly_ff <= (tdly_ff & ~wmask[19:0]) |
                     (wdata_ff[19:0] & wmask[19:0]);
        cts_pkg::TWID_OFS:
          twid_ff <= (twid_ff & ~wmask[14:0]) |
                     (wdata_ff[14:0] & wmask[14:0]);
        cts_pkg::SDLY_OFS:
          sdly_ff <= (sdly_ff & ~wmask[11:0]) |
                     (wdata_ff[11:0] & wmask[11:0]);
        cts_pkg::SWID_OFS:
          swid_ff <= (swid_ff & ~wmask[11:0]) |
                     (wdata_ff[11:0] & wmask[11:0]);
        default: ;
      endcase
    end
  end

  // Read channel, status shows live port states
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= cts_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= cts_pkg::RESP_OK;
      s_axi_rdata   <= 32'h0000_0000;
      case (s_axi_araddr)
        cts_pkg::CTRL_OFS: s_axi_rdata[2:0] <= ctrl_ff;
        cts_pkg::TDLY_OFS: s_axi_rdata[19:0] <= tdly_ff;
        cts_pkg::TWID_OFS: s_axi_rdata[14:0] <= twid_ff;
        cts_pkg::SDLY_OFS: s_axi_rdata[11:0] <= sdly_ff;
        cts_pkg::SWID_OFS: s_axi_rdata[11:0] <= swid_ff;
        cts_pkg::STAT_OFS: s_axi_rdata[2:0] <=
          {st_ff == cts_pkg::ST_IDLE, out_port, trig_on_ff}; // R8 R9
        default: s_axi_rresp <= cts_pkg::RESP_ERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Restart the divider as qualifying starts, so the width check in ST_QUAL
  // counts whole microseconds and a short pulse is never let through
  assign div_clr = st_ff == cts_pkg::ST_IDLE && nxt_st == cts_pkg::ST_QUAL;

  // Microsecond tick divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff  <= 7'h00;
      tick_ff <= 1'b0;
    end else if (div_clr) begin
      div_ff  <= 7'h00;
      tick_ff <= 1'b0;
    end else if (div_ff == 7'(cts_pkg::TICK_CYC - 1)) begin
      div_ff  <= 7'h00;
      tick_ff <= 1'b1; // R10
    end else begin
      div_ff  <= div_ff + 7'h01;
      tick_ff <= 1'b0;
    end
  end

  // Tick spacing watch; a restart marks the next period as partial
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_ff     <= 7'h00;
      tick_ok_ff <= 1'b0;
    end else if (tick_ff || div_clr) begin
      gap_ff     <= 7'h00;
      tick_ok_ff <= !div_clr;
    end else begin
      gap_ff <= gap_ff + 7'h01;
    end
  end

  // Pin synchroniser, level taken when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_ff    <= 3'h0;
      trig_on_ff <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[1:0], trigger_input_port};
      if (sync_ff[1] == sync_ff[2]) begin
        trig_on_ff <= sync_ff[2]; // R8
      end
    end
  end

  // Active level per trigger polarity
  assign trig_act = trig_on_ff ^ ctrl_ff[cts_pkg::TRIG_INV_BIT]; // R1

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_prev_ff <= 1'b0;
    end else begin
      act_prev_ff <= trig_act;
    end
  end

  // Limit for the present timed state
  always_comb begin
    case (st_ff)
      cts_pkg::ST_QUAL: limit = 20'(twid_ff); // R3
      cts_pkg::ST_TDLY: limit = tdly_ff; // R2
      cts_pkg::ST_SDLY: limit = 20'(sdly_ff); // R7
      cts_pkg::ST_SON:  limit = 20'(swid_ff); // R7
      default:          limit = 20'h00000;
    endcase
  end
  // Hit on the tick that completes the last microsecond; zero at once
  assign limit_hit = limit == 20'h00000 ||
                     (tick_ff && cnt_ff + 20'h00001 >= limit);

  // Sequencer next state
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      cts_pkg::ST_IDLE:
        if (trig_act && !act_prev_ff) begin
          nxt_st = cts_pkg::ST_QUAL;
        end
      cts_pkg::ST_QUAL:
        if (!trig_act) begin
          nxt_st = cts_pkg::ST_IDLE; // R3
        end else if (limit_hit) begin
          nxt_st = cts_pkg::ST_TDLY;
        end
      cts_pkg::ST_TDLY:
        if (limit_hit) begin
          nxt_st = ctrl_ff[cts_pkg::OUT_SEL_BIT] ?
                   cts_pkg::ST_SDLY : cts_pkg::ST_IDLE; // R7
        end
      cts_pkg::ST_SDLY:
        if (limit_hit) begin
          nxt_st = cts_pkg::ST_SON; // R5
        end
      cts_pkg::ST_SON:
        if (limit_hit) begin
          nxt_st = cts_pkg::ST_IDLE;
        end
      default: nxt_st = cts_pkg::ST_IDLE;
    endcase
  end

  // State, microsecond counter and shutter pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff           <= cts_pkg::ST_IDLE;
      cnt_ff          <= 20'h00000;
      shutter_release <= 1'b0;
    end else begin
      st_ff           <= nxt_st;
      shutter_release <= st_ff == cts_pkg::ST_TDLY && limit_hit; // R2
      if (nxt_st != st_ff) begin
        cnt_ff <= 20'h00000;
      end else if (tick_ff) begin
        cnt_ff <= cnt_ff + 20'h00001; // R10
      end
    end
  end

  // Output port: ready or strobe, then polarity; 1 means coupler on
  always_comb begin
    if (ctrl_ff[cts_pkg::OUT_SEL_BIT]) begin
      nxt_out = st_ff == cts_pkg::ST_SON; // R5
    end else begin
      nxt_out = st_ff == cts_pkg::ST_IDLE; // R4
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_port <= 1'b0;
    end else begin
      out_port <= nxt_out ^ ctrl_ff[cts_pkg::OUT_INV_BIT]; // R6
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_trig_polarity: // R1
    assert property (st_ff == cts_pkg::ST_IDLE && trig_act && !act_prev_ff
      |=> st_ff == cts_pkg::ST_QUAL)
    else $error("trigger edge not taken");
  a_trig_delay: // R2
    assert property (st_ff == cts_pkg::ST_TDLY && limit_hit
      |=> shutter_release)
    else $error("shutter not released after delay");
  a_width_abort: // R3
    assert property (st_ff == cts_pkg::ST_QUAL && !trig_act
      |=> st_ff == cts_pkg::ST_IDLE)
    else $error("short pulse accepted");
  a_ready_out: // R4
    assert property (!ctrl_ff[1] && !ctrl_ff[2]
      && $stable(ctrl_ff) |=> out_port == ($past(st_ff) == cts_pkg::ST_IDLE))
    else $error("ready output wrong");
  a_strobe_out: // R5
    assert property (ctrl_ff[1] && !ctrl_ff[2] && $stable(ctrl_ff)
      |=> out_port == ($past(st_ff) == cts_pkg::ST_SON))
    else $error("strobe output wrong");
  a_out_invert: // R6
    assert property ($stable(ctrl_ff) |=> out_port ==
      ($past(nxt_out) ^ $past(ctrl_ff[2])))
    else $error("output polarity wrong");
  a_ready_skip: // R7
    assert property (!ctrl_ff[1] && st_ff == cts_pkg::ST_TDLY && limit_hit
      |=> st_ff == cts_pkg::ST_IDLE)
    else $error("strobe timing used in ready mode");
  a_trig_mon: // R8
    assert property (sync_ff[2] == sync_ff[1] |=> trig_on_ff ==
      $past(sync_ff[2]))
    else $error("trigger monitor stale");
  a_tick_rate: // R10
    assert property (tick_ff && tick_ok_ff |->
      gap_ff == 7'(cts_pkg::TICK_CYC - 1))
    else $error("tick period not 100 cycles");
  a_tick_gap: // R10
    assert property (gap_ff <= 7'(cts_pkg::TICK_CYC))
    else $error("tick missing for too long");
  a_cnt_hold: // R10
    assert property (!tick_ff && nxt_st == st_ff |=> $stable(cnt_ff))
    else $error("counter moved without tick");

endmodule

/* cts_partner.sv */
// Model of the trigger sensor and strobe light beside the camera
`timescale 1ns/10ps
module cts_partner (
  input  wire logic        aclk,
  input  wire logic        on_req,
  input  wire logic        out_port,
  output logic             trigger_input_port = 1'b0,
  output logic [31:0]      lit_cyc = 32'h0
);
  logic [31:0] run_ff = 32'h0;
  // Sensor photocoupler follows the request one cycle late
  always @(posedge aclk) trigger_input_port <= on_req;
  // Light counts the cycles of each on phase of the output
  always @(posedge aclk) begin
    run_ff <= out_port ? run_ff + 32'h1 : 32'h0;
    if (!out_port && run_ff != 32'h0)
      lit_cyc <= run_ff;
  end
endmodule

/* tb.sv */
// Testbench for trigger conditioning and output port control
`timescale 1ns/10ps
module tb;
  logic        aclk = 0;
  logic        aresetn = 0;
  logic [7:0]  awaddr = 0;
  logic [7:0]  araddr = 0;
  logic        awvalid = 0;
  logic        wvalid = 0;
  logic        bready = 0;
  logic        arvalid = 0;
  logic        rready = 0;
  logic        on_req = 0;
  logic [31:0] wdata = 0;
  logic [31:0] seed = 32'd14123;
  logic        awready, wready, bvalid, arready, rvalid, pin, shut, outp;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, lit;
  logic [33:0] q [$];
  int          err_total = 0;
  int          checks_done = 0;
  int          n, k, w, d, s, p;
  logic [7:0]  ofs [5] = '{cts_pkg::CTRL_OFS, cts_pkg::TDLY_OFS,
    cts_pkg::TWID_OFS, cts_pkg::SDLY_OFS, cts_pkg::SWID_OFS};
  logic [31:0] msk [5] = '{32'h7, 32'hf_ffff, 32'h7fff, 32'hfff, 32'hfff};

  cts_trigger_strobe cts_trigger_strobe_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trigger_input_port(pin), .shutter_release(shut), .out_port(outp));
  cts_partner cts_partner_i (.aclk(aclk), .on_req(on_req), .out_port(outp),
    .trigger_input_port(pin), .lit_cyc(lit));

  // Clock of 10 ns
  initial forever #5 aclk = ~aclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(logic ok, string m);
    checks_done++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic lim(int c);
    if (c > 2000) begin
      chk(1'b0, "timeout");
      summarize();
    end
  endtask

  // Bus write, both channels offered together
  task automatic wr(logic [7:0] a, logic [31:0] v, logic [1:0] r);
    q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; bvalid !== 1'b1 || n == 0; n++) begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      lim(n);
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Bus read, expected answer noted for the watcher
  task automatic rd(logic [7:0] a, logic [33:0] e);
    q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; rvalid !== 1'b1 || n == 0; n++) begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
      lim(n);
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic cnt(int m, output int c);
    for (c = 0; c < m && shut !== 1'b1; c++)
      @(posedge aclk);
  endtask

  // Sensor goes active and is released once the shutter fires
  task automatic fire(logic lv, int m, output int c);
    on_req <= lv;
    cnt(m, c);
    on_req <= !lv;
  endtask

  task automatic waitx(logic v, int m, output int c);
    for (c = 0; outp !== v; c++) begin
      @(posedge aclk);
      lim(c * 2000 / m);
    end
  endtask

  // Watcher compares each bus answer with the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready)
      chk(q.pop_front() === {rresp, rdata}, "read answer");
    if (bvalid === 1'b1 && bready)
      chk(q.pop_front() === {bresp, 32'h0}, "write answer");
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, field widths and refused accesses
    for (int i = 0; i < 5; i++)
      rd(ofs[i], 34'h0);
    rd(cts_pkg::STAT_OFS, 34'h6);
    rd(8'h18, {cts_pkg::RESP_ERR, 32'h0});
    wr(8'h18, 32'h1, cts_pkg::RESP_ERR);
    wr(cts_pkg::STAT_OFS, 32'h0, cts_pkg::RESP_ERR);
    for (int i = 1; i < 5; i++) begin
      wr(ofs[i], 32'hffff_ffff, cts_pkg::RESP_OK);
      rd(ofs[i], {2'h0, msk[i]});
    end
    $display("test map done");
    // Qualified trigger, then delayed release
    w = int'(rnd() % 4) + 1;
    d = int'(rnd() % 4) + 1;
    wr(cts_pkg::TWID_OFS, w, cts_pkg::RESP_OK);
    wr(cts_pkg::TDLY_OFS, d, cts_pkg::RESP_OK);
    fire(1'b1, (w + d + 4) * 100, k);
    chk(k >= (w + d) * 100 && k <= (w + d + 2) * 100 + 20, "delay");
    repeat (3) @(posedge aclk);
    chk(outp === 1'b1, "ready level");
    $display("test release done");
    // Pulse shorter than the width is dropped
    on_req <= 1'b1;
    repeat (50) @(posedge aclk);
    rd(cts_pkg::STAT_OFS, 34'h1);
    on_req <= 1'b0;
    cnt(800, k);
    chk(k == 800, "short pulse");
    rd(cts_pkg::STAT_OFS, 34'h6);
    $display("test abort done");
    // Strobe pulses, plain and inverted
    for (int i = 0; i < 2; i++) begin
      s = int'(rnd() % 3) + 1;
      p = int'(rnd() % 3) + 1;
      wr(cts_pkg::SDLY_OFS, s, cts_pkg::RESP_OK);
      wr(cts_pkg::SWID_OFS, p, cts_pkg::RESP_OK);
      wr(cts_pkg::CTRL_OFS, 32'(i * 4 + 2), cts_pkg::RESP_OK);
      repeat (2) @(posedge aclk);
      chk(outp === 1'(i), "idle level");
      fire(1'b1, (w + d + 4) * 100, k);
      waitx(1'(i == 0), (s + 2) * 100, k);
      chk(k + 10 >= s * 100 && k <= (s + 1) * 100 + 20, "strobe delay");
      waitx(1'(i), (p + 2) * 100, k);
      chk(k >= p * 100 && k <= (p + 1) * 100 + 20, "strobe width");
      @(posedge aclk);
      if (i == 0)
        chk(lit === 32'(k), "light on time");
    end
    $display("test strobe done");
    // Inverted trigger fires with the sensor off
    wr(cts_pkg::CTRL_OFS, 32'h1, cts_pkg::RESP_OK);
    cnt((w + d + 4) * 100, k);
    chk(k + 10 >= (w + d) * 100 && k <= (w + d + 2) * 100 + 20, "invert");
    $display("test invert done");
    summarize();
  end
endmodule
